// [fcd_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defs.vh"

// Summary of operation
// - Thirty-two balanced global trees, each usable as clock or control.
// - Eight regional networks for core and side interfaces, each local to its region.
// - Top and bottom interface regions share one regional network, one half each.
// - Left and right halves of each regional network are driven independently.
// - Every global and regional network has run-time enable gating that never glitches its output.
// - Global buffer cells drive the global trees from core or interface; regional halves select their sources directly.
// - Eight dynamic multiplexers, two per side, switchable during user operation.
// - After configuration every dynamic multiplexer selects input 0.
// - Pin clocks enter the networks only through positive-leg pins.
// - Receive clock lanes feed global by default, regional as alternative.
// - Every loop output clock connects to the global network.
// - Serial link and spread-spectrum word clocks reach global and regional trees.
// - 80-row regions hold 40-row local networks; memory and arithmetic separate.
// - Each core local network takes 16 signals from global, fabric, regional.
// - Eight regional signals reach top and bottom local networks, four elsewhere.
// - Local fabric drives each logic cell clock enable through one register stage, one cycle late.
// - Top or bottom interface regions: 16 clocks, 14 global and 2 fabric.
// - Left or right interface regions: 4 clocks, at most 2 from fabric.
module fcd_top #(
	parameter N_PIN = 8,
	parameter N_PLL = 8,
	parameter N_WORD = 4,
	parameter N_LANE = 4,
	parameter SW = 6,
	parameter IS_EDGE = 0,
	parameter N_CE = 16
) (
	input wire i_clock,
	input wire i_rstn,
	input wire [N_PIN-1:0] i_pin_p_clk,
	input wire [N_PLL-1:0] i_pll_clk,
	input wire i_osc_clk,
	input wire [N_WORD-1:0] i_word_clk,
	input wire [N_LANE-1:0] i_lane_clk,
	input wire [N_LANE-1:0] i_lane_rgn,
	input wire [`FCD_LOC_FAB-1:0] i_fab_clk,
	input wire [`FCD_N_GLB*SW-1:0] i_global_buffer_cell_sel,
	input wire [`FCD_N_GLB-1:0] i_glb_dyn,
	input wire [`FCD_N_GLB-1:0] i_glb_en,
	input wire [`FCD_N_DMUX*`FCD_DMUX_IN*SW-1:0] i_dmux_map,
	input wire [`FCD_N_DMUX-1:0] i_dmux_en,
	input wire [`FCD_N_DMUX*`FCD_DMUX_SELW-1:0] i_dmux_sel,
	input wire [(2*`FCD_N_RGN+2*`FCD_N_EDGE_RGN)*SW-1:0] i_rgn_sel,
	input wire [2*`FCD_N_RGN+2*`FCD_N_EDGE_RGN-1:0] i_rgn_en,
	input wire [4*`FCD_LOC_W*6-1:0] i_loc_sel,
	input wire [2*`FCD_TB_GLB*5-1:0] i_tb_sel,
	input wire [2*`FCD_TB_FAB-1:0] i_tb_fab,
	input wire [2*`FCD_LR_CLK*6-1:0] i_lr_sel,
	input wire [2*`FCD_LR_FAB-1:0] i_lr_use_fab,
	input wire [2*`FCD_LR_FAB-1:0] i_lr_fab,
	input wire [N_CE-1:0] i_fab_ce,
	output wire [`FCD_N_GLB-1:0] o_glb_clk,
	output wire [2*`FCD_N_RGN-1:0] o_rgn_clk,
	output wire [2*`FCD_N_EDGE_RGN-1:0] o_edge_rgn_clk,
	output wire [4*`FCD_LOC_W-1:0] o_loc_clk,
	output wire [2*`FCD_TB_CLK-1:0] o_tb_clk,
	output wire [2*`FCD_LR_CLK-1:0] o_lr_clk,
	output wire [N_CE-1:0] o_logic_routing_cell_ce,
	output wire [`FCD_N_DMUX-1:0] o_dmux_busy,
	output wire [`FCD_N_DMUX*`FCD_DMUX_SELW-1:0] o_dmux_cur
);

	// Two 40-row segments per column plus memory and arithmetic networks
	localparam N_LOC = `FCD_REGION_ROWS / `FCD_LOC_ROWS + 2;
	localparam N_EXT = N_PIN + N_PLL + 1 + N_WORD + N_LANE;
	localparam N_POOL = N_EXT + `FCD_LOC_FAB;
	localparam N_RT = 2 * `FCD_N_RGN + 2 * `FCD_N_EDGE_RGN;

	// Out-of-range selections yield a quiet low rather than an unknown
	function pick;
		input [63:0] v;
		input [5:0] idx;
		begin
			pick = v[idx];
		end
	endfunction

	// ----------------------------------------------------------------
	// Source capture
	// ----------------------------------------------------------------
	// Sources come from other domains, so they are sampled twice first
	reg [N_EXT-1:0] ext_m_r;
	reg [N_EXT-1:0] ext_s_r;

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			ext_m_r <= {N_EXT{1'b0}};
			ext_s_r <= {N_EXT{1'b0}};
		end else begin
			ext_m_r <= {i_lane_clk, i_word_clk, i_osc_clk, i_pll_clk, i_pin_p_clk};
			ext_s_r <= ext_m_r;
		end
	end

	wire [N_PIN-1:0] s_pin = ext_s_r[N_PIN-1:0];
	wire [N_PLL-1:0] s_pll = ext_s_r[N_PIN+N_PLL-1:N_PIN];
	wire s_osc = ext_s_r[N_PIN+N_PLL];
	wire [N_WORD-1:0] s_word = ext_s_r[N_PIN+N_PLL+N_WORD:N_PIN+N_PLL+1];
	wire [N_LANE-1:0] s_lane = ext_s_r[N_EXT-1:N_EXT-N_LANE];

	// ----------------------------------------------------------------
	// Source pools
	// ----------------------------------------------------------------
	// Select index map shared by the buffer cells, muxes and regional halves:
	//   0 to 7    positive-leg pin clocks
	//   8 to 15   loop output clocks
	//   16        oscillator, global pool only; reads low in the regional pool
	//   17 to 20  serial link word clocks
	//   21 to 24  receive clock lanes, global or regional as steered
	//   25 to 40  fabric signals, taken without synchronisers
	//   above 40  quiet low
	// Fabric signals already live in this clock domain, so they skip the
	// two-stage capture and arrive two cycles ahead of external sources.
	// Software that lines up a fabric clock against a pin clock has to
	// allow for that skew.
	// Global pool: every loop output and the oscillator; lanes unless steered away
	wire [N_POOL-1:0] glb_pool = {i_fab_clk, s_lane & ~i_lane_rgn, s_word, s_osc, s_pll, s_pin};
	// Regional pool: no oscillator, lanes only when steered here
	wire [N_POOL-1:0] rgn_pool = {i_fab_clk, s_lane & i_lane_rgn, s_word, 1'b0, s_pll, s_pin};
	wire [63:0] glb_pool64 = {{(64-N_POOL){1'b0}}, glb_pool};
	wire [63:0] rgn_pool64 = {{(64-N_POOL){1'b0}}, rgn_pool};

	// ----------------------------------------------------------------
	// Dynamic multiplexers
	// ----------------------------------------------------------------
	// Muxes 2k and 2k+1 sit on side k
	// A switch takes at least two busy cycles: one to drop the old input on
	// its low level and one to add the new input on its own low level.
	// The mux output stays low in between, so the tree sees a long low
	// phase rather than a runt pulse. Select changes made while busy are
	// held off; the request is looked at again once the mux is back in RUN.
	// The trade is switching latency for a clean output.
	wire [`FCD_N_DMUX-1:0] dmux_out;
	genvar k;
	genvar j;
	generate
		for (k = 0; k < `FCD_N_DMUX; k = k + 1) begin : g_dmux
			reg [1:0] st_r;
			reg [`FCD_DMUX_SELW-1:0] cur_r;
			reg [`FCD_DMUX_SELW-1:0] tgt_r;
			reg act_r;
			reg out_r;
			wire [`FCD_DMUX_IN-1:0] ins;
			wire [`FCD_DMUX_SELW-1:0] sel = i_dmux_sel[k*`FCD_DMUX_SELW +: `FCD_DMUX_SELW];
			for (j = 0; j < `FCD_DMUX_IN; j = j + 1) begin : g_in
				assign ins[j] = pick(glb_pool64, i_dmux_map[(k*`FCD_DMUX_IN+j)*SW +: SW]);
			end
			reg [1:0] st_nxt;
			reg [`FCD_DMUX_SELW-1:0] cur_nxt;
			reg [`FCD_DMUX_SELW-1:0] tgt_nxt;
			reg act_nxt;
			wire cur_lvl = ins[cur_r];
			// A clock stopped high stalls the switch in DROP or PICK; the busy flag shows it
			always @* begin
				st_nxt = st_r;
				cur_nxt = cur_r;
				tgt_nxt = tgt_r;
				act_nxt = act_r;
				case (st_r)
					`FCD_ST_RUN: begin
						if (i_dmux_en[k] && sel != cur_r) begin
							tgt_nxt = sel;
							st_nxt = `FCD_ST_DROP;
						end
					end
					`FCD_ST_DROP: begin
						if (!cur_lvl) begin
							act_nxt = 1'b0;
							cur_nxt = tgt_r;
							st_nxt = `FCD_ST_PICK;
						end
					end
					`FCD_ST_PICK: begin
						if (!cur_lvl) begin
							act_nxt = 1'b1;
							st_nxt = `FCD_ST_RUN;
						end
					end
					default: begin
						st_nxt = `FCD_ST_RUN;
					end
				endcase
			end
			// Next state kept apart so every path assigns every field
			always @(posedge i_clock) begin
				if (!i_rstn) begin
					st_r <= `FCD_ST_RUN;
					cur_r <= `FCD_DMUX_DEF_SEL;
					tgt_r <= `FCD_DMUX_DEF_SEL;
					act_r <= 1'b1;
					out_r <= 1'b0;
				end else begin
					out_r <= cur_lvl & act_r;
					st_r <= st_nxt;
					cur_r <= cur_nxt;
					tgt_r <= tgt_nxt;
					act_r <= act_nxt;
				end
			end
			assign dmux_out[k] = out_r;
			assign o_dmux_busy[k] = (st_r != `FCD_ST_RUN);
			assign o_dmux_cur[k*`FCD_DMUX_SELW +: `FCD_DMUX_SELW] = cur_r;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Global and regional trees
	// ----------------------------------------------------------------
	wire [`FCD_N_GLB-1:0] glb_src;
	wire [N_RT-1:0] rgn_src;
	generate
		for (k = 0; k < `FCD_N_GLB; k = k + 1) begin : g_glb
			if (k < `FCD_N_DMUX) begin : g_dyn
				assign glb_src[k] = i_glb_dyn[k] ? dmux_out[k]
					: pick(glb_pool64, i_global_buffer_cell_sel[k*SW +: SW]);
			end else begin : g_sta
				assign glb_src[k] = pick(glb_pool64, i_global_buffer_cell_sel[k*SW +: SW]);
			end
		end
		// Halves 2r and 2r+1 are left and right of region r; last two are top, bottom
		for (k = 0; k < N_RT; k = k + 1) begin : g_rgn
			assign rgn_src[k] = pick(rgn_pool64, i_rgn_sel[k*SW +: SW]);
		end
	endgenerate

	reg [`FCD_N_GLB-1:0] glb_en_r;
	reg [`FCD_N_GLB-1:0] glb_r;
	reg [N_RT-1:0] rgn_en_r;
	reg [N_RT-1:0] rgn_r;

	// Enables move only while the source is low, so no pulse is ever cut short
	// While the source is high the old enable simply holds itself
	wire [`FCD_N_GLB-1:0] glb_en_nxt = (glb_en_r & glb_src) | (i_glb_en & ~glb_src);
	wire [N_RT-1:0] rgn_en_nxt = (rgn_en_r & rgn_src) | (i_rgn_en & ~rgn_src);

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			glb_en_r <= {`FCD_N_GLB{1'b0}};
			glb_r <= {`FCD_N_GLB{1'b0}};
		end else begin
			glb_en_r <= glb_en_nxt;
			glb_r <= glb_src & glb_en_r;
		end
	end

	// Regional halves gate the same way, each on its own source
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			rgn_en_r <= {N_RT{1'b0}};
			rgn_r <= {N_RT{1'b0}};
		end else begin
			rgn_en_r <= rgn_en_nxt;
			rgn_r <= rgn_src & rgn_en_r;
		end
	end

	assign o_glb_clk = glb_r;
	assign o_rgn_clk = rgn_r[2*`FCD_N_RGN-1:0];
	assign o_edge_rgn_clk = rgn_r[N_RT-1:2*`FCD_N_RGN];

	// ----------------------------------------------------------------
	// Local networks
	// ----------------------------------------------------------------
	// Local select index map:
	//   0 to 31   global trees
	//   32 to 47  fabric signals from other regions
	//   48 to 55  regional halves; 52 to 55 read low outside edge regions
	// Local nets 0 and 1 are the two 40-row segments of a column,
	// 2 serves memory and 3 arithmetic.
	// Edge regions see eight regional signals, others only four
	wire [7:0] rgn_loc = (IS_EDGE != 0) ? rgn_r[7:0] : {4'h0, rgn_r[3:0]};
	wire [63:0] loc_pool = {8'h00, rgn_loc, i_fab_clk, glb_r};
	wire [63:0] lr_pool = {16'h0000, rgn_r[2*`FCD_N_RGN-1:0], glb_r};
	wire [63:0] tb_pool = {32'h00000000, glb_r};

	// Top and bottom slots 0 to 13 take a global tree, 14 and 15 the fabric.
	// Side slots 0 and 1 may take the fabric; every side slot may take a
	// global tree (0 to 31) or a regional half (32 to 47).
	// A side fabric slot left unused falls back to the buffered trees; top and bottom slots 14 and 15 always take the fabric.
	wire [N_LOC*`FCD_LOC_W-1:0] loc_nxt;
	wire [2*`FCD_TB_CLK-1:0] tb_nxt;
	wire [2*`FCD_LR_CLK-1:0] lr_nxt;

	generate
		for (k = 0; k < N_LOC*`FCD_LOC_W; k = k + 1) begin : g_loc
			assign loc_nxt[k] = pick(loc_pool, i_loc_sel[k*6 +: 6]);
		end
		for (k = 0; k < 2; k = k + 1) begin : g_edge
			for (j = 0; j < `FCD_TB_GLB; j = j + 1) begin : g_tbg
				assign tb_nxt[k*`FCD_TB_CLK+j] =
					pick(tb_pool, {1'b0, i_tb_sel[(k*`FCD_TB_GLB+j)*5 +: 5]});
			end
			for (j = 0; j < `FCD_TB_FAB; j = j + 1) begin : g_tbf
				assign tb_nxt[k*`FCD_TB_CLK+`FCD_TB_GLB+j] = i_tb_fab[k*`FCD_TB_FAB+j];
			end
			for (j = 0; j < `FCD_LR_CLK; j = j + 1) begin : g_lr
				if (j < `FCD_LR_FAB) begin : g_f
					assign lr_nxt[k*`FCD_LR_CLK+j] = i_lr_use_fab[k*`FCD_LR_FAB+j]
						? i_lr_fab[k*`FCD_LR_FAB+j]
						: pick(lr_pool, i_lr_sel[(k*`FCD_LR_CLK+j)*6 +: 6]);
				end else begin : g_b
					// Remaining slots reach only buffered trees
					assign lr_nxt[k*`FCD_LR_CLK+j] =
						pick(lr_pool, i_lr_sel[(k*`FCD_LR_CLK+j)*6 +: 6]);
				end
			end
		end
	endgenerate

	// One register stage on every local output keeps them all aligned
	// one cycle behind their tree, whatever the source
	reg [N_LOC*`FCD_LOC_W-1:0] loc_r;
	reg [2*`FCD_TB_CLK-1:0] tb_r;
	reg [2*`FCD_LR_CLK-1:0] lr_r;
	reg [N_CE-1:0] ce_r;

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			loc_r <= {(N_LOC*`FCD_LOC_W){1'b0}};
			tb_r <= {(2*`FCD_TB_CLK){1'b0}};
			lr_r <= {(2*`FCD_LR_CLK){1'b0}};
			ce_r <= {N_CE{1'b0}};
		end else begin
			loc_r <= loc_nxt;
			tb_r <= tb_nxt;
			lr_r <= lr_nxt;
			ce_r <= i_fab_ce;
		end
	end

	assign o_loc_clk = loc_r;
	assign o_tb_clk = tb_r;
	assign o_lr_clk = lr_r;
	assign o_logic_routing_cell_ce = ce_r;

endmodule // fcd_top

`default_nettype wire

// [fcd_defs.vh]
`ifndef FCD_DEFS_VH
`define FCD_DEFS_VH

// Network counts
`define FCD_N_GLB 32
`define FCD_N_RGN 8
`define FCD_N_EDGE_RGN 1
`define FCD_N_DMUX 8
`define FCD_DMUX_PER_SIDE 2
`define FCD_DMUX_IN 4
`define FCD_DMUX_SELW 2
`define FCD_DMUX_DEF_SEL 2'h0

// Dynamic multiplexer states
`define FCD_ST_RUN 2'h0
`define FCD_ST_DROP 2'h1
`define FCD_ST_PICK 2'h2

// Local network limits
`define FCD_REGION_ROWS 80
`define FCD_LOC_ROWS 40
`define FCD_LOC_W 16
`define FCD_LOC_FAB 16
`define FCD_RGN_LOC_EDGE 8
`define FCD_RGN_LOC_CORE 4
`define FCD_TB_CLK 16
`define FCD_TB_GLB 14
`define FCD_TB_FAB 2
`define FCD_LR_CLK 4
`define FCD_LR_FAB 2

`endif

// [fcd_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fcd_src_model (
	output wire logic [24:0] o_src
);
	// Pin, loop, oscillator, word and lane clocks on unrelated periods from fast
	// to slow; they run from time zero and never stop, so input 0 toggles first
	for (genvar g = 0; g < 25; g++) begin : g_src
		logic clk_r = 1'b0;
		always #(113 + g * 21) clk_r = ~clk_r;
		assign o_src[g] = clk_r;
	end
endmodule // fcd_src_model
`default_nettype wire

// [fcd_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defs.vh"
module fcd_monitor #(
	parameter N_CE = 16
) (
	input wire i_clock,
	input wire i_rstn,
	input wire [N_CE-1:0] i_fab_ce,
	input wire [`FCD_N_GLB-1:0] i_glb_en,
	input wire [`FCD_N_DMUX-1:0] i_dmux_en,
	input wire [`FCD_N_DMUX*`FCD_DMUX_SELW-1:0] i_dmux_sel,
	input wire [`FCD_N_GLB-1:0] o_glb_clk,
	input wire [N_CE-1:0] o_logic_routing_cell_ce,
	input wire [`FCD_N_DMUX-1:0] o_dmux_busy,
	input wire [`FCD_N_DMUX*`FCD_DMUX_SELW-1:0] o_dmux_cur
);
	// Mux 0 and tree 1 stand for the rest: the bench exercises those
	wire busy = o_dmux_busy[0];
	wire [1:0] cur = o_dmux_cur[1:0];
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence sw_req;
		!busy && i_dmux_en[0] && i_dmux_sel[1:0] != cur;
	endsequence
	sequence sw_hold;
		busy [*2];
	endsequence
	ce_delay_a: assert property ($past(i_rstn) |->
		o_logic_routing_cell_ce == $past(i_fab_ce)) else $error("enable delay wrong");
	reset_idle_a: assert property (!$past(i_rstn) |->
		o_dmux_cur == '0 && o_dmux_busy == '0) else $error("mux not on input 0");
	busy_start_a: assert property (sw_req |=> sw_hold)
		else $error("switch start wrong");
	busy_idle_a: assert property (!busy && !(i_dmux_en[0] && i_dmux_sel[1:0] != cur)
		|=> !busy) else $error("switch without request");
	cur_hold_a: assert property (!busy |=> $stable(cur))
		else $error("input moved while idle");
	cur_change_a: assert property ($past(i_rstn) && $changed(cur) |-> busy && $past(busy))
		else $error("new input not added after old dropped");
	switch_bound_a: assert property ($rose(busy) |-> ##[2:60] !busy)
		else $error("switch length wrong");
	gate_off_a: assert property ((!i_glb_en[1] && !o_glb_clk[1]) [*3] |=> !o_glb_clk[1])
		else $error("disabled tree toggled");
endmodule // fcd_monitor
bind fcd_top fcd_monitor #(.N_CE(N_CE)) i_monitor (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_fab_ce(i_fab_ce), .i_glb_en(i_glb_en),
	.i_dmux_en(i_dmux_en), .i_dmux_sel(i_dmux_sel), .o_glb_clk(o_glb_clk),
	.o_logic_routing_cell_ce(o_logic_routing_cell_ce), .o_dmux_busy(o_dmux_busy),
	.o_dmux_cur(o_dmux_cur));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic [15:0] fab_clk = '0, fab_ce = '0, dsel = '0;
	logic [191:0] gsel = '0, dmap = '0;
	logic [31:0] glb_dyn = '0, glb_en = '0;
	logic [7:0] den = '0;
	logic [3:0] lane_rgn = '0;
	logic [107:0] rsel = '0;
	logic [17:0] ren = '0;
	logic [383:0] lsel = '0;
	logic [139:0] tbsel = '0;
	logic [47:0] lrsel = '0;
	logic [3:0] tbfab = '0, lruse = '0, lrfab = '0;
	wire [1:0] edg;
	wire [31:0] tbc;
	wire [7:0] lrc;
	wire [24:0] src;
	wire [31:0] glb;
	wire [15:0] rgn, ce, cur;
	wire [63:0] loc;
	wire [7:0] busy;
	wire [153:0] mon = {lrc, tbc, edg, loc, rgn, glb};
	int miscompares = 0;
	int checks_done = 0;
	always #25 i_clock = ~i_clock;
	fcd_src_model i_src (.o_src(src));
	fcd_top i_dut (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_pin_p_clk(src[7:0]), .i_pll_clk(src[15:8]),
		.i_osc_clk(src[16]), .i_word_clk(src[20:17]), .i_lane_clk(src[24:21]),
		.i_lane_rgn(lane_rgn), .i_fab_clk(fab_clk), .i_global_buffer_cell_sel(gsel),
		.i_glb_dyn(glb_dyn), .i_glb_en(glb_en), .i_dmux_map(dmap), .i_dmux_en(den),
		.i_dmux_sel(dsel), .i_rgn_sel(rsel), .i_rgn_en(ren), .i_loc_sel(lsel),
		.i_tb_sel(tbsel), .i_tb_fab(tbfab), .i_lr_sel(lrsel), .i_lr_use_fab(lruse),
		.i_lr_fab(lrfab), .i_fab_ce(fab_ce), .o_glb_clk(glb), .o_rgn_clk(rgn),
		.o_edge_rgn_clk(edg), .o_loc_clk(loc), .o_tb_clk(tbc), .o_lr_clk(lrc),
		.o_logic_routing_cell_ce(ce), .o_dmux_busy(busy), .o_dmux_cur(cur));
	task automatic summarize();
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	// Counts settled highs and lows; the fabric clock toggles meanwhile
	task automatic watch(input int b, input int n, output int hi, output int lo);
		hi = 0;
		lo = 0;
		repeat (n) begin
			tick(1);
			fab_clk[0] = ~fab_clk[0];
			hi += (mon[b] === 1'b1);
			lo += (mon[b] === 1'b0);
		end
	endtask
	task automatic wait_idle();
		int n = 0;
		while (busy[0] !== 1'b0 && n < 100) begin
			tick(1);
			n++;
		end
		check("switch end", n < 100, 1);
	endtask
	task automatic t_ce();
		logic [15:0] pat[4] = '{16'hA5C3, 16'h5A3C, 16'hFFFF, 16'h0000};
		foreach (pat[i]) begin
			fab_ce = pat[i];
			tick(1);
			check("cell enable", ce, pat[i]);
		end
	endtask
	task automatic t_trees();
		int hi, lo;
		int srcs[6] = '{0, 8, 16, 17, 21, 25};
		foreach (srcs[i]) begin
			gsel[11:6] = srcs[i][5:0];
			glb_en[1] = 1'b1;
			watch(1, 60, hi, lo);
			check("tree on", {hi > 0, lo > 0}, 2'h3);
			glb_en[1] = 1'b0;
			watch(1, 30, hi, lo);
			watch(1, 30, hi, lo);
			check("tree off", hi, 0);
		end
	endtask
	task automatic t_regions();
		int hi, lo;
		lane_rgn = 4'h1;
		rsel[5:0] = 6'h15;
		ren[0] = 1'b1;
		lsel[5:0] = 6'h30;
		gsel[11:6] = 6'h15;
		glb_en[1] = 1'b1;
		watch(32, 60, hi, lo);
		check("region half", {hi > 0, lo > 0}, 2'h3);
		watch(48, 40, hi, lo);
		check("local net", {hi > 0, lo > 0}, 2'h3);
		watch(33, 30, hi, lo);
		check("other half", hi, 0);
		watch(1, 30, hi, lo);
		check("lane off tree", hi, 0);
	endtask
	task automatic t_edges();
		int hi, lo;
		gsel[11:6] = 6'h00;
		glb_en[1] = 1'b1;
		rsel[101:96] = 6'h00;
		ren[16] = 1'b1;
		tbsel[4:0] = 5'h01;
		lrsel[5:0] = 6'h01;
		lrsel[17:12] = 6'h20;
		watch(112, 60, hi, lo);
		check("top region", {hi > 0, lo > 0}, 2'h3);
		watch(113, 30, hi, lo);
		check("bottom region", hi, 0);
		watch(114, 60, hi, lo);
		check("top interface", {hi > 0, lo > 0}, 2'h3);
		watch(146, 60, hi, lo);
		check("side slot", {hi > 0, lo > 0}, 2'h3);
		watch(148, 60, hi, lo);
		check("side regional", {hi > 0, lo > 0}, 2'h3);
		tbfab[0] = 1'b1;
		lruse[0] = 1'b1;
		lrfab[0] = 1'b1;
		tick(2);
		check("top fabric", tbc[14], 1);
		check("side fabric", lrc[0], 1);
		tbfab[0] = 1'b0;
		lrfab[0] = 1'b0;
		tick(2);
		check("fabric low", {tbc[14], lrc[0]}, 2'h0);
	endtask
	task automatic t_switch();
		int hi, lo;
		int seq[4] = '{1, 3, 2, 0};
		dmap[23:0] = {6'h0B, 6'h0A, 6'h09, 6'h08};
		glb_dyn[0] = 1'b1;
		glb_en[0] = 1'b1;
		dsel[1:0] = 2'h1;
		tick(3);
		check("disabled mux", {busy[0], cur[1:0]}, 3'h0);
		den[0] = 1'b1;
		foreach (seq[i]) begin
			dsel[1:0] = seq[i][1:0];
			tick(1);
			check("busy", busy[0], 1);
			wait_idle();
			check("input", cur[1:0], seq[i]);
			watch(0, 40, hi, lo);
			check("mux tree", {hi > 0, lo > 0}, 2'h3);
		end
		dsel[1:0] = 2'h1;
		tick(2);
		dsel[1:0] = 2'h2;
		wait_idle();
		check("late select", cur[1:0], 1);
		tick(1);
		check("retaken", busy[0], 1);
		wait_idle();
		check("second input", cur[1:0], 2);
	endtask
	initial begin
		#1000000;
		miscompares++;
		summarize();
	end
	initial begin
		tick(16);
		i_rstn = 1'b1;
		check("reset input", cur, 0);
		check("reset busy", busy, 0);
		t_ce();
		t_trees();
		t_regions();
		t_edges();
		t_switch();
		summarize();
	end
endmodule // tb
`default_nettype wire
